// ==== verilog/ddscc_defs.svh ====
// constants: offsets, fields, reset values and timing counts
`ifndef DDSCC_DEFS_SVH
`define DDSCC_DEFS_SVH
// word offsets of registers (printed offsets kept as indices)
`define DDSCC_IDX_CFG_ONE 6'h00
`define DDSCC_IDX_CFG_TWO 6'h01
`define DDSCC_IDX_CFG_THREE 6'h02
`define DDSCC_IDX_CFG_FOUR 6'h03
`define DDSCC_IDX_FREQ 6'h04
`define DDSCC_IDX_PHASE_AMP 6'h0c
`define DDSCC_IDX_STATUS 6'h1b
// field positions
`define DDSCC_BIT_SINE_SEL 16
`define DDSCC_BIT_OSC_CAL 24
`define DDSCC_BIT_PLL_EN 18
`define DDSCC_BIT_MOD_EN 0
`define DDSCC_BIT_DAC_CAL 24
`define DDSCC_BIT_LOCK 24
`define DDSCC_BIT_OSC_BUSY 1
`define DDSCC_BIT_DAC_BUSY 0
`define DDSCC_FLD_FB_LO 8
`define DDSCC_FB_MIN 8'h0a
`define DDSCC_FB_MAX 8'hff
// reset values
`define DDSCC_RST_CFG_ONE 32'h0000_0000
`define DDSCC_RST_CFG_THREE 32'h0000_1900
`define DDSCC_RST_FREQ 32'h0000_0000
`define DDSCC_RST_PHASE_AMP 32'h0fff_0000
// timing
`define DDSCC_DAC_CAL_CYCLES 469632
`define DDSCC_MOD_PERIOD 24
`define DDSCC_OSC_CAL_CYCLES 1024
`define DDSCC_LOCK_CYCLES 256
`endif

// ==== verilog/ddscc_pkg.sv ====
// types shared by the synthesizer core
package ddscc_pkg;
  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [11:0] amp;
    logic sine_sel;
  } ddscc_ctrl_t;
  typedef enum logic [1:0] {
    ddscc_cal_idle = 2'b00,
    ddscc_cal_osc = 2'b01,
    ddscc_cal_dac = 2'b10
  } ddscc_cal_t;
endpackage : ddscc_pkg

// ==== verilog/ddscc_sine_rom.sv ====
// full-wave parabolic sine generator, combinational
`timescale 1ns/1ps
module ddscc_sine_rom
  import ddscc_pkg::*;
(
  input wire logic [15:0] phase,
  output logic signed [11:0] value
);
  // ---------------------------------------------------------------------
  // parabolic approximation: keeps area tiny, costs some spur purity
  // ---------------------------------------------------------------------
  // one parabola per half cycle; the peak is clipped to 11 bits
  function automatic logic [10:0] ddscc_half(input logic [14:0] x);
    logic [15:0] rest;
    logic [31:0] p;
    rest = 16'h8000 - {1'b0, x};
    p = {17'h00000, x} * {16'h0000, rest};
    ddscc_half = p[28] ? 11'h7ff : p[27:17];
  endfunction : ddscc_half
  wire [10:0] mag = ddscc_half(phase[14:0]);
  wire [11:0] mag_ext = {1'b0, mag};
  assign value = phase[15] ? -$signed(mag_ext) : $signed(mag_ext);
endmodule : ddscc_sine_rom

// ==== verilog/ddscc_skid.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ddscc_skid #(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic [1:0] cnt_r;
  logic rd_r, wr_r;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;
  assign in_ready = cnt_r != 2'd2;
  assign out_valid = cnt_r != 2'd0;
  assign out_data = mem_r[rd_r];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_r[wr_r] <= in_data;
  end
endmodule : ddscc_skid

// ==== verilog/ddscc_core.sv ====
// synthesizer core: accumulator, offset, scaling, calibration sequencing
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ddscc_defs.svh"
module ddscc_core
  import ddscc_pkg::*;
#(
  parameter int DAC_CAL_CYCLES = `DDSCC_DAC_CAL_CYCLES,
  parameter int OSC_CAL_CYCLES = `DDSCC_OSC_CAL_CYCLES,
  parameter int LOCK_CYCLES = `DDSCC_LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ref_stable,
  input wire logic pll_locked_in,
  input wire logic [31:0] mod_data,
  input wire logic mod_valid,
  output logic mod_ready,
  output logic [11:0] dac_sample,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic pll_path_sel,
  output logic [8:0] pll_mult,
  output logic pll_locked
);
  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [31:0] cfg_one_r, cfg_two_r, cfg_three_r, cfg_four_r;
  logic [31:0] freq_r;
  logic [31:0] phase_amp_r;
  logic wait_r;
  logic [31:0] rdata_r;
  ddscc_cal_t cal_r, cal_nxt;
  logic [18:0] cal_cnt_r;
  logic osc_trig_q_r, dac_trig_q_r, osc_done_r;
  logic dac_done_r;
  logic [8:0] lock_cnt_r;
  logic lock_r;
  logic [4:0] mod_cnt_r;
  logic [31:0] acc_r;
  ddscc_ctrl_t live_r;
  logic [11:0] samp_r;
  logic samp_v_r;
  logic [11:0] dac_r;
  logic dac_v_r;

  // ---------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------
  function automatic logic [31:0] ddscc_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    ddscc_merge = old;
  endfunction : ddscc_merge
  wire [5:0] idx = avs_address[7:2];
  wire req = (avs_read || avs_write) && wait_r;
  // write lands on the edge where waitrequest is seen low
  wire wr_go = ce && avs_write && !wait_r;
  wire hit_one = idx == `DDSCC_IDX_CFG_ONE;
  wire hit_two = idx == `DDSCC_IDX_CFG_TWO;
  wire hit_three = idx == `DDSCC_IDX_CFG_THREE;
  wire hit_four = idx == `DDSCC_IDX_CFG_FOUR;
  wire hit_freq = idx == `DDSCC_IDX_FREQ;
  wire hit_pa = idx == `DDSCC_IDX_PHASE_AMP;
  wire hit_stat = idx == `DDSCC_IDX_STATUS;
  wire [31:0] status_w = ({31'h0, lock_r} << `DDSCC_BIT_LOCK) |
    ({31'h0, cal_r == ddscc_cal_osc} << `DDSCC_BIT_OSC_BUSY) |
    ({31'h0, cal_r == ddscc_cal_dac} << `DDSCC_BIT_DAC_BUSY) |
    ({31'h0, osc_done_r} << 2) | ({31'h0, dac_done_r} << 3);
  wire [31:0] rd_mux = hit_one ? cfg_one_r : hit_two ? cfg_two_r :
    hit_three ? cfg_three_r : hit_four ? cfg_four_r :
    hit_freq ? freq_r : hit_pa ? phase_amp_r :
    hit_stat ? status_w : 32'h0000_0000;
  // divider field limited to its legal range on write
  wire [31:0] three_m = ddscc_merge(cfg_three_r, avs_writedata,
                                    avs_byteenable);
  wire [7:0] fb_raw = three_m[15:8];
  wire [7:0] fb_ok = (fb_raw < `DDSCC_FB_MIN) ? `DDSCC_FB_MIN : fb_raw;
  wire [31:0] three_nxt = {three_m[31:16], fb_ok, three_m[7:0]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      wait_r <= !req;
      if (req && avs_read) rdata_r <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_one_r <= `DDSCC_RST_CFG_ONE;
      cfg_two_r <= 32'h0000_0000;
      cfg_three_r <= `DDSCC_RST_CFG_THREE;
      cfg_four_r <= 32'h0000_0000;
      freq_r <= `DDSCC_RST_FREQ;
      phase_amp_r <= `DDSCC_RST_PHASE_AMP;
    end else if (wr_go) begin
      if (hit_one) cfg_one_r <= ddscc_merge(cfg_one_r, avs_writedata,
                                           avs_byteenable);
      if (hit_two) cfg_two_r <= ddscc_merge(cfg_two_r, avs_writedata,
                                           avs_byteenable);
      if (hit_three) cfg_three_r <= three_nxt;
      if (hit_four) cfg_four_r <= ddscc_merge(cfg_four_r, avs_writedata,
                                             avs_byteenable);
      if (hit_freq) freq_r <= ddscc_merge(freq_r, avs_writedata,
                                          avs_byteenable);
      if (hit_pa) phase_amp_r <= ddscc_merge(phase_amp_r, avs_writedata,
                                             avs_byteenable);
    end
  end

  // ---------------------------------------------------------------------
  // calibration sequencer
  // ---------------------------------------------------------------------
  wire osc_trig = cfg_one_r[`DDSCC_BIT_OSC_CAL];
  wire dac_trig = cfg_four_r[`DDSCC_BIT_DAC_CAL];
  wire osc_rise = osc_trig && !osc_trig_q_r;
  // trigger level is written by software; the clear of the bit starts DAC calibration
  wire dac_fall = !dac_trig && dac_trig_q_r;
  wire pll_en = cfg_three_r[`DDSCC_BIT_PLL_EN];
  wire cal_end = cal_cnt_r == 19'd1;
  always_comb begin
    cal_nxt = cal_r;
    unique case (cal_r)
      ddscc_cal_idle: begin
        if (osc_rise && pll_en && ref_stable) cal_nxt = ddscc_cal_osc;
        else if (dac_fall) cal_nxt = ddscc_cal_dac;
      end
      ddscc_cal_osc: if (cal_end) cal_nxt = ddscc_cal_idle;
      ddscc_cal_dac: if (cal_end) cal_nxt = ddscc_cal_idle;
      default: cal_nxt = ddscc_cal_idle;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_r <= ddscc_cal_idle;
      cal_cnt_r <= 19'd0;
      osc_trig_q_r <= 1'b0;
      dac_trig_q_r <= 1'b0;
      osc_done_r <= 1'b0;
      dac_done_r <= 1'b0;
    end else if (ce) begin
      cal_r <= cal_nxt;
      osc_trig_q_r <= osc_trig;
      dac_trig_q_r <= dac_trig;
      if (cal_r == ddscc_cal_idle && cal_nxt == ddscc_cal_osc) begin
        cal_cnt_r <= 19'(OSC_CAL_CYCLES);
        osc_done_r <= 1'b0;
      end else if (cal_r == ddscc_cal_idle && cal_nxt == ddscc_cal_dac) begin
        cal_cnt_r <= 19'(DAC_CAL_CYCLES);
        dac_done_r <= 1'b0;
      end else if (cal_r != ddscc_cal_idle) begin
        cal_cnt_r <= cal_cnt_r - 19'd1;
        if (cal_end && cal_r == ddscc_cal_osc) osc_done_r <= 1'b1;
        if (cal_end && cal_r == ddscc_cal_dac) dac_done_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // clock path and lock flag
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt_r <= 9'd0;
      lock_r <= 1'b0;
      pll_path_sel <= 1'b0;
      pll_mult <= 9'h000;
    end else if (ce) begin
      pll_path_sel <= pll_en;
      pll_mult <= {cfg_three_r[15:8], 1'b0};
      // qualified lock: never claimed during oscillator calibration
      if (!pll_en || !pll_locked_in || cal_r == ddscc_cal_osc) begin
        lock_cnt_r <= 9'd0;
        lock_r <= 1'b0;
      end else if (lock_cnt_r != 9'(LOCK_CYCLES)) begin
        lock_cnt_r <= lock_cnt_r + 9'd1;
      end else begin
        lock_r <= 1'b1;
      end
    end
  end
  assign pll_locked = lock_r;

  // ---------------------------------------------------------------------
  // modulation: one parameter word taken every 24 clocks at most
  // ---------------------------------------------------------------------
  wire mod_en = cfg_two_r[`DDSCC_BIT_MOD_EN];
  wire [1:0] mod_dest = cfg_two_r[2:1];
  wire mod_slot = mod_cnt_r == 5'd0;
  wire mod_take = ce && mod_en && mod_valid && mod_slot;
  wire dst_f = mod_en && mod_dest == 2'd0;
  wire dst_p = mod_en && mod_dest == 2'd1;
  wire dst_a = mod_en && mod_dest[1];
  // modulated value holds until the next slot, never reverts early
  wire [31:0] freq_sel = !dst_f ? freq_r :
    mod_take ? mod_data : live_r.freq;
  wire [15:0] phase_sel = !dst_p ? phase_amp_r[15:0] :
    mod_take ? mod_data[31:16] : live_r.phase;
  wire [11:0] amp_sel = !dst_a ? phase_amp_r[27:16] :
    mod_take ? mod_data[31:20] : live_r.amp;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_cnt_r <= 5'd0;
      mod_ready <= 1'b0;
    end else if (ce) begin
      if (mod_take) mod_cnt_r <= 5'(`DDSCC_MOD_PERIOD - 1);
      else if (!mod_slot) mod_cnt_r <= mod_cnt_r - 5'd1;
      mod_ready <= mod_en && (mod_cnt_r <= 5'd1) && !mod_take;
    end
  end

  // ---------------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------------
  wire stall = dac_v_r && !dac_ready;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      live_r <= '0;
    end else if (ce) begin
      live_r.sine_sel <= cfg_one_r[`DDSCC_BIT_SINE_SEL];
      live_r.freq <= freq_sel;
      live_r.phase <= phase_sel;
      live_r.amp <= amp_sel;
    end
  end
  // phase accumulator: adds the live frequency word on every enabled clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) acc_r <= 32'h0000_0000;
    else if (ce) acc_r <= acc_r + live_r.freq;
  end
  wire [15:0] lut_phase = acc_r[31:16] + live_r.phase +
                          (live_r.sine_sel ? 16'h0000 : 16'h4000);
  logic signed [11:0] wave;
  ddscc_sine_rom u_rom (
    .phase(lut_phase),
    .value(wave)
  );
  wire signed [24:0] prod = wave * $signed({1'b0, live_r.amp});
  wire [11:0] scaled = prod[23:12];
  wire [11:0] offset_bin = {~scaled[11], scaled[10:0]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_r <= 12'h800;
      samp_v_r <= 1'b0;
    end else if (ce && (buf_in_ready || !samp_v_r)) begin
      // a full buffer holds this word, so a stall loses none
      samp_r <= offset_bin;
      samp_v_r <= cal_r != ddscc_cal_dac;
    end
  end
  logic [11:0] buf_data;
  logic buf_valid, buf_in_ready;
  ddscc_skid #(.WIDTH(12)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(samp_v_r),
    .in_ready(buf_in_ready),
    .in_data(samp_r),
    .out_valid(buf_valid),
    .out_ready(!stall),
    .out_data(buf_data)
  );
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_r <= 12'h800;
      dac_v_r <= 1'b0;
    end else if (ce && !stall) begin
      dac_r <= buf_data;
      dac_v_r <= buf_valid;
    end
  end
  assign dac_sample = dac_r;
  assign dac_valid = dac_v_r;
endmodule : ddscc_core

// ==== dv/ddscc_core_chk.sv ====
// checker: bus answer, clock path and sample stream properties
`timescale 1ns/1ps
module ddscc_core_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic [7:0] avs_address,
  input wire logic avs_waitrequest,
  input wire logic mod_valid,
  input wire logic mod_ready,
  input wire logic [11:0] dac_sample,
  input wire logic dac_valid,
  input wire logic dac_ready,
  input wire logic pll_locked_in,
  input wire logic pll_path_sel,
  input wire logic [8:0] pll_mult,
  input wire logic pll_locked
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rq = (avs_read || avs_write) && ce;
  wire st_rd = avs_read && !avs_waitrequest && avs_address == 8'h6c;
  AST_BUS_ANSWER: assert property (
    rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one wait state");
  AST_BUS_ONE: assert property (
    ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer stood longer than one cycle");
  AST_LOCK_READ: assert property (
    st_rd && $stable(pll_locked) |-> avs_readdata[24] == pll_locked)
    else $error("status lock bit differs from lock output");
  AST_LOCK_CAUSE: assert property (
    $rose(pll_locked) |-> $past(pll_locked_in) && pll_path_sel)
    else $error("lock rose without loop lock on pll path");
  AST_MULT_EVEN: assert property (
    pll_mult == 9'h000 || (!pll_mult[0] && pll_mult >= 9'd20))
    else $error("multiplier odd or below twenty");
  AST_PATH_WRITE: assert property (
    $changed(pll_path_sel) |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("clock path changed without a write");
  AST_STALL_HOLD: assert property (
    ce && dac_valid && !dac_ready |=> dac_valid && $stable(dac_sample))
    else $error("sample lost or changed under stall");
  AST_MOD_GAP: assert property (
    $fell(mod_ready) && mod_valid |-> ##1 !mod_ready [*8])
    else $error("modulation word accepted too soon");
  // cover: lock, stall and modulation take
  COV_LOCK: cover property ($rose(pll_locked));
  COV_STALL: cover property (dac_valid && !dac_ready);
  COV_MOD: cover property ($fell(mod_ready) && mod_valid);
endmodule : ddscc_core_chk

bind ddscc_core ddscc_core_chk ddscc_core_chk_i (.clk(clk), .rst_b(rst_b),
  .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_address(avs_address),
  .avs_waitrequest(avs_waitrequest), .mod_valid(mod_valid),
  .mod_ready(mod_ready), .dac_sample(dac_sample), .dac_valid(dac_valid),
  .dac_ready(dac_ready), .pll_locked_in(pll_locked_in),
  .pll_path_sel(pll_path_sel), .pll_mult(pll_mult),
  .pll_locked(pll_locked));

// ==== dv/ddscc_far_model.sv ====
// far side model: reference source, loop lock and converter sink
`timescale 1ns/1ps
module ddscc_far_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pll_path_sel,
  input wire logic stall,
  output logic ref_stable,
  output logic pll_locked_in,
  output logic dac_ready
);
  // ----------------------------------------
  // loop settling
  // ----------------------------------------
  logic [5:0] cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cnt_r <= 6'h00;
    else if (!pll_path_sel)
      cnt_r <= 6'h00;
    else if (cnt_r != 6'h3f)
      cnt_r <= cnt_r + 6'h01;
  end
  // reference settles first, so calibration is never asked too early
  assign ref_stable = cnt_r >= 6'h04;
  assign pll_locked_in = cnt_r >= 6'h20;
  assign dac_ready = !stall;
endmodule : ddscc_far_model

// ==== dv/tb_top.sv ====
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
`include "ddscc_defs.svh"
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DCAL = 64;
  localparam logic [7:0] A_C1 = {`DDSCC_IDX_CFG_ONE, 2'b00};
  localparam logic [7:0] A_C2 = {`DDSCC_IDX_CFG_TWO, 2'b00};
  localparam logic [7:0] A_C3 = {`DDSCC_IDX_CFG_THREE, 2'b00};
  localparam logic [7:0] A_C4 = {`DDSCC_IDX_CFG_FOUR, 2'b00};
  localparam logic [7:0] A_FR = {`DDSCC_IDX_FREQ, 2'b00};
  localparam logic [7:0] A_PA = {`DDSCC_IDX_PHASE_AMP, 2'b00};
  localparam logic [7:0] A_ST = {`DDSCC_IDX_STATUS, 2'b00};
  logic clk, rst_b, avs_read, avs_write, mod_valid, stall;
  logic avs_waitrequest, mod_ready, dac_valid, dac_ready;
  logic pll_path_sel, pll_locked, ref_stable, pll_locked_in;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, mod_data, rd;
  logic [11:0] dac_sample, s;
  logic [8:0] pll_mult;
  int n_mismatch, tests_run, cyc, t;
  ddscc_core #(.DAC_CAL_CYCLES(DCAL), .OSC_CAL_CYCLES(16),
    .LOCK_CYCLES(4)) ddscc_core_i (.clk, .rst_b, .ce(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .ref_stable, .pll_locked_in,
    .mod_data, .mod_valid, .mod_ready, .dac_sample, .dac_valid, .dac_ready,
    .pll_path_sel, .pll_mult, .pll_locked);
  ddscc_far_model ddscc_far_model_i (.clk, .rst_b, .pll_path_sel, .stall,
    .ref_stable, .pll_locked_in, .dac_ready);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, v);
      n_mismatch++;
    end
  endtask : chk
  // holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("bus answer", 1, i < 40);
    if (i >= 40) give_verdict;
  endtask : bus
  task poll(input int b);
    int k;
    t = cyc;
    k = 0;
    do begin
      bus(1'b0, A_ST, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 300);
    t = cyc - t;
    chk("status poll", 1, rd[b]);
    if (k >= 300) give_verdict;
  endtask : poll
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    repeat (8) @(posedge clk);
    chk("cos zero", 1, dac_sample >= 12'hf00);
    bus(1'b0, A_C1, 32'h0);
    chk("cfg one", `DDSCC_RST_CFG_ONE, rd);
    bus(1'b0, A_C3, 32'h0);
    chk("cfg three", `DDSCC_RST_CFG_THREE, rd);
    bus(1'b0, A_PA, 32'h0);
    chk("phase amp", `DDSCC_RST_PHASE_AMP, rd);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("t_regs done");
  endtask : t_regs
  task t_pll;
    bus(1'b1, A_C3, 32'h0004_0500);
    repeat (4) @(posedge clk);
    chk("mult min", 20, pll_mult);
    chk("pll path", 1, pll_path_sel);
    bus(1'b1, A_C3, 32'h0004_ff00);
    repeat (4) @(posedge clk);
    chk("mult max", 510, pll_mult);
    bus(1'b1, A_C1, 32'h0100_0000);
    bus(1'b0, A_ST, 32'h0);
    chk("osc busy", 1, rd[1]);
    poll(2);
    bus(1'b1, A_C1, 32'h0100_0000);
    bus(1'b0, A_ST, 32'h0);
    chk("osc no rerun", 0, rd[1]);
    bus(1'b1, A_C1, 32'h0);
    poll(`DDSCC_BIT_LOCK);
    chk("lock out", 1, pll_locked);
    bus(1'b1, A_C3, 32'h0000_1900);
    repeat (4) @(posedge clk);
    chk("direct path", 0, pll_path_sel);
    bus(1'b0, A_ST, 32'h0);
    chk("unlocked", 0, rd[24]);
    $display("t_pll done");
  endtask : t_pll
  task t_dac;
    bus(1'b1, A_C4, 32'h0100_0000);
    bus(1'b1, A_C4, 32'h0);
    bus(1'b0, A_ST, 32'h0);
    chk("dac busy", 1, rd[0]);
    poll(3);
    chk("dac length", 1, t >= DCAL - 10 && t <= DCAL + 6);
    $display("t_dac done");
  endtask : t_dac
  task t_wave;
    bus(1'b1, A_C1, 32'h0001_0000);
    repeat (8) @(posedge clk);
    chk("sine zero", 1, dac_sample >= 12'h7f0 && dac_sample <= 12'h810);
    bus(1'b1, A_PA, 32'h0fff_4000);
    repeat (8) @(posedge clk);
    chk("offset", 1, dac_sample >= 12'hf00);
    bus(1'b1, A_PA, 32'h0800_4000);
    repeat (8) @(posedge clk);
    chk("scale", 1, dac_sample >= 12'hb80 && dac_sample <= 12'hc40);
    bus(1'b1, A_C1, 32'h0);
    bus(1'b1, A_PA, 32'h0fff_0000);
    bus(1'b1, A_FR, 32'h8000_0000);
    repeat (8) @(posedge clk);
    s = dac_sample;
    @(posedge clk);
    chk("half rate", 1, (s > dac_sample ? s - dac_sample :
        dac_sample - s) >= 12'he00);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    s = dac_sample;
    repeat (5) @(posedge clk);
    chk("stall hold", s, dac_sample);
    chk("stall valid", 1, dac_valid);
    stall <= 1'b0;
    bus(1'b1, A_FR, 32'h0);
    $display("t_wave done");
  endtask : t_wave
  task t_mod;
    int k;
    logic pr;
    bus(1'b1, A_C2, 32'h1);
    mod_data <= 32'h0100_0000;
    mod_valid <= 1'b1;
    k = 0;
    pr = 1'b1;
    repeat (120) begin
      @(posedge clk);
      if (mod_ready === 1'b1 && pr !== 1'b1) k++;
      pr = mod_ready;
    end
    mod_valid <= 1'b0;
    chk("mod rate", 1, k >= 1 && k <= 6);
    // amplitude destination: a zero scale must hold between slots
    bus(1'b1, A_C2, 32'h5);
    mod_data <= 32'h0;
    mod_valid <= 1'b1;
    repeat (40) @(posedge clk);
    chk("mod amp take", 12'h800, dac_sample);
    mod_valid <= 1'b0;
    repeat (30) @(posedge clk);
    chk("mod amp hold", 12'h800, dac_sample);
    bus(1'b1, A_C2, 32'h0);
    $display("t_mod done");
  endtask : t_mod
  initial begin
    {avs_read, avs_write, mod_valid, stall} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    mod_data = 32'h0;
    {n_mismatch, tests_run, cyc} = 0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_pll;
    t_dac;
    t_wave;
    t_mod;
    give_verdict;
  end
endmodule : tb_top
